/* File: hdl/psb_sequencer.sv */
// Power-path, protection and bleeder sequencer with AHB-Lite registers
// Contract
// - Reference is 10-bit code, 20 mV steps
// - Reference code follows negotiated contract voltage
// - Current loop enabled only during contract
// - Over-current mode: voltage only, amp decoupled
// - Debounced over-current flags fault, starts restart
// - Green mode while no sink attached
// - Bleeders only on under light load
// - Voltage step: output bleeder, timed 7/19/56/224ms
// - Detach or hard reset: bleed 224ms
// - Protection: both bleeders, switch off, 224ms
// - All faults merge into one trigger
// - Protection: switch off, both bleeders on
// - Protection active: both pull-ups off
// - Faults clear: input bleeder, start restart timer
// - Restart expiry re-enables both pull-ups
// - Attach after debounce in sink window
// - Over-voltage delayed and blanked during transitions
`timescale 1ns/1ns
`default_nettype none
module psb_sequencer #(
   parameter int unsigned BLEED_A = psb_pkg::BLEED_A_CYC,
   parameter int unsigned BLEED_B = psb_pkg::BLEED_B_CYC,
   parameter int unsigned BLEED_C = psb_pkg::BLEED_C_CYC,
   parameter int unsigned BLEED_D = psb_pkg::BLEED_D_CYC,
   parameter int unsigned RESTART = psb_pkg::RESTART_CYC,
   parameter int unsigned ATTACH_DEB = psb_pkg::ATTACH_DEB_CYC,
   parameter int unsigned OCP_DEB = psb_pkg::OCP_DEB_CYC,
   parameter int unsigned OVP_DEL = psb_pkg::OVP_DEL_CYC,
   parameter int unsigned OVP_BLANK = psb_pkg::OVP_BLANK_CYC
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire psb_pkg::sense_s sense,
   output psb_pkg::drive_s drive,
   output logic irq
);
   // All module state
   typedef struct packed {
      logic [10:0] sync1; // First synchroniser stage
      logic [10:0] sync2; // Second synchroniser stage
      psb_pkg::seq_e state; // Sequencer state
      logic [31:0] timer; // State timer
      logic [31:0] attach_cnt; // Attach debounce count
      logic [31:0] ocp_cnt; // Over-current debounce count
      logic [31:0] ovp_cnt; // Over-voltage delay count
      logic [31:0] blank_cnt; // Over-voltage blank count
      logic attached; // Debounced sink present
      logic ocp_fault; // Debounced over-current fault
      logic ovp_fault; // Delayed over-voltage fault
      logic contract; // Contract in force
      logic cc_mode; // Constant current selected
      logic hard_rst; // Pending hard reset
      logic [psb_pkg::CODE_W-1:0] vreq; // Requested code
      logic [psb_pkg::EV_W-1:0] ev_stat; // Sticky events
      logic [psb_pkg::EV_W-1:0] ev_mask; // Event mask
      logic ap_valid; // Data phase pending
      logic ap_write; // Pending is a write
      logic [7:0] ap_addr; // Pending offset
      logic [31:0] rdata; // Read data
      logic ready_out; // Bus ready
      psb_pkg::drive_s drv; // Registered drive
      logic irq_out; // Interrupt output
   } st_s;

   st_s s_r;
   st_s s_nxt;
   psb_pkg::sense_s in; // Synchronised inputs
   logic sink_window; // Either line in sink window
   logic fault_raw; // Undebounced fault sources
   logic trigger; // Common protection trigger
   logic [psb_pkg::CODE_W-1:0] target; // Code the contract wants
   logic [psb_pkg::CODE_W-1:0] step; // Size of the voltage step
   logic [psb_pkg::EV_W-1:0] events; // Events this cycle
   logic [psb_pkg::EV_W-1:0] w1c; // Bits software clears
   logic bleed_ok; // Light load lets bleeders on

   // Next-state logic
   always_comb
   begin
      s_nxt = s_r;
      events = '0;
      w1c = '0;
      // Two-stage synchroniser for analog comparator outputs
      s_nxt.sync1 = sense;
      s_nxt.sync2 = s_r.sync1;
      in = psb_pkg::sense_s'(s_r.sync2);
      sink_window = in.cc1_in_window | in.cc2_in_window;
      bleed_ok = in.light_load;
      target = s_r.contract ? s_r.vreq : psb_pkg::CODE_SAFE5;
      step = (target > s_r.drv.voltage_reference_level) ? target - s_r.drv.voltage_reference_level
         : s_r.drv.voltage_reference_level - target;

      // Bus data phase: write side
      if (s_r.ap_valid && s_r.ap_write)
      begin
         case (s_r.ap_addr)
            psb_pkg::OFF_CTRL:
            begin
               s_nxt.contract = hwdata[psb_pkg::CTRL_CONTRACT];
               s_nxt.cc_mode = hwdata[psb_pkg::CTRL_CC_MODE];
               if (hwdata[psb_pkg::CTRL_HARD_RST])
               begin
                  s_nxt.hard_rst = 1'b1;
               end
            end
            psb_pkg::OFF_VREQ: s_nxt.vreq = hwdata[psb_pkg::CODE_W-1:0];
            psb_pkg::OFF_IRQ_STAT: w1c = hwdata[psb_pkg::EV_W-1:0];
            psb_pkg::OFF_IRQ_MASK: s_nxt.ev_mask = hwdata[psb_pkg::EV_W-1:0];
            default: ; // Unmapped: ignored
         endcase
      end

      // Bus address phase: capture and prepare read data
      s_nxt.ap_valid = hsel && htrans[1] && hready;
      s_nxt.ap_write = hwrite;
      s_nxt.ap_addr = haddr[7:0];
      s_nxt.rdata = '0;
      if (hsel && htrans[1] && hready && !hwrite)
      begin
         case (haddr[7:0])
            psb_pkg::OFF_CTRL: s_nxt.rdata = {29'h0000_0000, s_r.hard_rst, s_r.cc_mode, s_r.contract};
            psb_pkg::OFF_VREQ: s_nxt.rdata = {22'h00_0000, s_r.vreq};
            psb_pkg::OFF_STATUS: s_nxt.rdata = {14'h0000, s_r.drv.voltage_reference_level,
               s_r.ovp_fault, s_r.ocp_fault, s_r.attached, 2'h0, s_r.state};
            psb_pkg::OFF_IRQ_STAT: s_nxt.rdata = {26'h000_0000, s_r.ev_stat};
            psb_pkg::OFF_IRQ_MASK: s_nxt.rdata = {26'h000_0000, s_r.ev_mask};
            default: s_nxt.rdata = '0; // Unmapped reads zero
         endcase
      end
      s_nxt.ready_out = 1'b1;

      // Sink attach and detach debounce
      if (s_r.state == psb_pkg::ST_PROTECT || s_r.state == psb_pkg::ST_RESTART)
      begin
         s_nxt.attached = 1'b0;
         s_nxt.attach_cnt = '0;
      end
      else if (sink_window != s_r.attached)
      begin
         s_nxt.attach_cnt = s_r.attach_cnt + 32'h0000_0001;
         if (s_r.attach_cnt >= ATTACH_DEB - 1)
         begin
            s_nxt.attached = sink_window;
            s_nxt.attach_cnt = '0;
            events[psb_pkg::EV_ATTACH] = sink_window;
            events[psb_pkg::EV_DETACH] = !sink_window;
         end
      end
      else
      begin
         s_nxt.attach_cnt = '0;
      end

      // Over-current debounce, only in over-current mode
      if (s_r.contract && !s_r.cc_mode && in.over_current && s_r.drv.load_switch_gate)
      begin
         s_nxt.ocp_cnt = s_r.ocp_cnt + 32'h0000_0001;
         if (s_r.ocp_cnt >= OCP_DEB - 1 && !s_r.ocp_fault)
         begin
            s_nxt.ocp_fault = 1'b1;
            events[psb_pkg::EV_OCP] = 1'b1;
         end
      end
      else
      begin
         s_nxt.ocp_cnt = '0;
      end

      // Over-voltage delay, blanked around voltage steps
      if (s_r.blank_cnt != 32'h0000_0000)
      begin
         s_nxt.blank_cnt = s_r.blank_cnt - 32'h0000_0001;
      end
      if (in.over_voltage && s_r.blank_cnt == 32'h0000_0000 && s_r.state != psb_pkg::ST_TRANSITION)
      begin
         s_nxt.ovp_cnt = s_r.ovp_cnt + 32'h0000_0001;
         if (s_r.ovp_cnt >= OVP_DEL - 1)
         begin
            s_nxt.ovp_fault = 1'b1;
         end
      end
      else
      begin
         s_nxt.ovp_cnt = '0;
      end

      // Common protection trigger
      // Over-voltage enters only through its delayed, blanked fault
      fault_raw = in.under_voltage | in.ext_over_temp | in.int_over_temp | in.cable_fault
         | in.cc_over_voltage;
      trigger = fault_raw | s_r.ovp_fault | s_r.ocp_fault;

      // Sequencer
      if (s_r.timer != 32'h0000_0000)
      begin
         s_nxt.timer = s_r.timer - 32'h0000_0001;
      end
      if (trigger && s_r.state != psb_pkg::ST_PROTECT)
      begin
         // Protection overrides every other activity
         s_nxt.state = psb_pkg::ST_PROTECT;
         s_nxt.timer = BLEED_D;
         events[psb_pkg::EV_PROTECT] = 1'b1;
      end
      else
      begin
         case (s_r.state)
            psb_pkg::ST_DETACHED:
            begin
               s_nxt.drv.voltage_reference_level = psb_pkg::CODE_SAFE5;
               if (s_r.attached)
               begin
                  s_nxt.state = psb_pkg::ST_ATTACHED;
               end
            end
            psb_pkg::ST_ATTACHED:
            begin
               if (!s_r.attached || s_r.hard_rst)
               begin
                  // Detach or hard reset: bleed back down
                  s_nxt.hard_rst = 1'b0;
                  s_nxt.contract = 1'b0;
                  s_nxt.state = psb_pkg::ST_DISCHARGE;
                  s_nxt.timer = BLEED_D;
                  s_nxt.drv.voltage_reference_level = psb_pkg::CODE_SAFE5;
               end
               else if (target != s_r.drv.voltage_reference_level)
               begin
                  // Contract voltage change with timed bleed
                  s_nxt.drv.voltage_reference_level = target;
                  s_nxt.state = psb_pkg::ST_TRANSITION;
                  s_nxt.blank_cnt = OVP_BLANK;
                  if (step <= psb_pkg::CODE_SMALL_STEP)
                  begin
                     s_nxt.timer = (target >= psb_pkg::CODE_HIGH_V) ? BLEED_A : BLEED_B;
                  end
                  else
                  begin
                     s_nxt.timer = (target >= psb_pkg::CODE_HIGH_V) ? BLEED_C : BLEED_D;
                  end
               end
            end
            psb_pkg::ST_TRANSITION:
            begin
               if (s_r.timer <= 32'h0000_0001)
               begin
                  s_nxt.timer = '0;
                  s_nxt.state = psb_pkg::ST_ATTACHED;
                  s_nxt.blank_cnt = OVP_BLANK;
                  events[psb_pkg::EV_BLEED_DONE] = 1'b1;
               end
            end
            psb_pkg::ST_DISCHARGE:
            begin
               if (s_r.timer <= 32'h0000_0001)
               begin
                  s_nxt.timer = '0;
                  s_nxt.state = psb_pkg::ST_DETACHED;
                  s_nxt.hard_rst = 1'b0;
                  events[psb_pkg::EV_BLEED_DONE] = 1'b1;
               end
            end
            psb_pkg::ST_PROTECT:
            begin
               s_nxt.contract = 1'b0;
               s_nxt.drv.voltage_reference_level = psb_pkg::CODE_SAFE5;
               if (s_r.timer <= 32'h0000_0001 && !fault_raw && !in.over_voltage)
               begin
                  // Faults gone: start the restart wait
                  s_nxt.ocp_fault = 1'b0;
                  s_nxt.ovp_fault = 1'b0;
                  s_nxt.hard_rst = 1'b0;
                  s_nxt.state = psb_pkg::ST_RESTART;
                  s_nxt.timer = RESTART;
               end
            end
            psb_pkg::ST_RESTART:
            begin
               if (s_r.timer <= 32'h0000_0001)
               begin
                  s_nxt.timer = '0;
                  s_nxt.state = psb_pkg::ST_DETACHED;
                  events[psb_pkg::EV_RESTART] = 1'b1;
               end
            end
            default: s_nxt.state = psb_pkg::ST_DETACHED;
         endcase
      end

      // Drive outputs from the next state
      s_nxt.drv.cc_loop_enable = s_nxt.contract && s_nxt.cc_mode;
      s_nxt.drv.current_amp_decouple = !(s_nxt.contract && s_nxt.cc_mode);
      s_nxt.drv.green_mode = !s_nxt.attached;
      s_nxt.drv.sync_rect_enable = s_nxt.attached;
      s_nxt.drv.line1_pullup_current = 1'b1;
      s_nxt.drv.line2_pullup_current = 1'b1;
      s_nxt.drv.output_bleeder = 1'b0;
      s_nxt.drv.input_bleeder = 1'b0;
      s_nxt.drv.load_switch_gate = 1'b0;
      case (s_nxt.state)
         psb_pkg::ST_ATTACHED: s_nxt.drv.load_switch_gate = 1'b1;
         psb_pkg::ST_TRANSITION:
         begin
            s_nxt.drv.output_bleeder = bleed_ok;
            s_nxt.drv.load_switch_gate = 1'b1;
         end
         psb_pkg::ST_DISCHARGE:
         begin
            s_nxt.drv.output_bleeder = bleed_ok;
            s_nxt.drv.input_bleeder = bleed_ok && !in.vbus_above_safe5v;
            s_nxt.drv.load_switch_gate = in.vbus_above_safe5v;
         end
         psb_pkg::ST_PROTECT:
         begin
            s_nxt.drv.output_bleeder = bleed_ok;
            s_nxt.drv.input_bleeder = bleed_ok;
            s_nxt.drv.line1_pullup_current = 1'b0;
            s_nxt.drv.line2_pullup_current = 1'b0;
         end
         psb_pkg::ST_RESTART:
         begin
            s_nxt.drv.input_bleeder = bleed_ok;
            s_nxt.drv.line1_pullup_current = 1'b0;
            s_nxt.drv.line2_pullup_current = 1'b0;
         end
         default: ; // Detached: all off, pull-ups on
      endcase

      // Sticky events, a new event beats the clear
      s_nxt.ev_stat = (s_r.ev_stat & ~w1c) | events;
      s_nxt.irq_out = |(s_nxt.ev_stat & s_nxt.ev_mask);
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r <= '0;
         s_r.ready_out <= 1'b1;
         s_r.drv.voltage_reference_level <= psb_pkg::CODE_SAFE5;
         s_r.drv.line1_pullup_current <= 1'b1;
         s_r.drv.line2_pullup_current <= 1'b1;
         s_r.drv.green_mode <= 1'b1;
         s_r.drv.current_amp_decouple <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register; hresp tied to okay
   assign hrdata = s_r.rdata;
   assign hreadyout = s_r.ready_out;
   assign hresp = 1'b0;
   assign drive = s_r.drv;
   assign irq = s_r.irq_out;
endmodule
`default_nettype wire

/* File: include/psb_pkg.sv */
// Shared constants, types and states of the power-path sequencer
`default_nettype none
package psb_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00; // Contract and mode control
   localparam logic [7:0] OFF_VREQ = 8'h04; // Requested output code
   localparam logic [7:0] OFF_STATUS = 8'h08; // Live state
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0C; // Sticky events, write one to clear
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10; // Event enables
   // Control bit positions
   localparam int CTRL_CONTRACT = 0; // Contract in force
   localparam int CTRL_CC_MODE = 1; // One: constant current, zero: over-current mode
   localparam int CTRL_HARD_RST = 2; // Write one: hard reset pulse
   // Event bit positions
   localparam int EV_ATTACH = 0;
   localparam int EV_DETACH = 1;
   localparam int EV_OCP = 2;
   localparam int EV_PROTECT = 3;
   localparam int EV_RESTART = 4;
   localparam int EV_BLEED_DONE = 5;
   localparam int EV_W = 6;
   // Reference code: 10 bits, 20 mV per step
   localparam int CODE_W = 10;
   localparam int STEP_MV = 20;
   localparam int SAFE5_MV = 5000;
   localparam int SMALL_STEP_MV = 500;
   localparam int HIGH_V_MV = 13000;
   localparam logic [CODE_W-1:0] CODE_SAFE5 = CODE_W'(SAFE5_MV / STEP_MV);
   localparam logic [CODE_W-1:0] CODE_SMALL_STEP = CODE_W'(SMALL_STEP_MV / STEP_MV);
   localparam logic [CODE_W-1:0] CODE_HIGH_V = CODE_W'(HIGH_V_MV / STEP_MV);
   // Clock rate and times
   localparam int unsigned CLK_KHZ = 25000;
   localparam int unsigned BLEED_A_MS = 7;
   localparam int unsigned BLEED_B_MS = 19;
   localparam int unsigned BLEED_C_MS = 56;
   localparam int unsigned BLEED_D_MS = 224;
   localparam int unsigned RESTART_MS = 2000;
   localparam int unsigned ATTACH_DEB_US = 150;
   localparam int unsigned OCP_DEB_US = 1000;
   localparam int unsigned OVP_DEL_US = 100;
   localparam int unsigned OVP_BLANK_US = 1000;
   localparam int unsigned BLEED_A_CYC = BLEED_A_MS * CLK_KHZ;
   localparam int unsigned BLEED_B_CYC = BLEED_B_MS * CLK_KHZ;
   localparam int unsigned BLEED_C_CYC = BLEED_C_MS * CLK_KHZ;
   localparam int unsigned BLEED_D_CYC = BLEED_D_MS * CLK_KHZ;
   localparam int unsigned RESTART_CYC = RESTART_MS * CLK_KHZ;
   localparam int unsigned ATTACH_DEB_CYC = ATTACH_DEB_US * CLK_KHZ / 1000;
   localparam int unsigned OCP_DEB_CYC = OCP_DEB_US * CLK_KHZ / 1000;
   localparam int unsigned OVP_DEL_CYC = OVP_DEL_US * CLK_KHZ / 1000;
   localparam int unsigned OVP_BLANK_CYC = OVP_BLANK_US * CLK_KHZ / 1000;
   // Sequencer states
   typedef enum logic [2:0] {ST_DETACHED, ST_ATTACHED, ST_TRANSITION, ST_DISCHARGE, ST_PROTECT,
      ST_RESTART} seq_e;
   // Analog comparator inputs
   typedef struct packed {
      logic cc1_in_window; // Line 1 in sink-detect window
      logic cc2_in_window; // Line 2 in sink-detect window
      logic over_current; // Load above over-current threshold
      logic light_load; // Load below bleeder enable current limit
      logic over_voltage; // Output above over-voltage threshold
      logic under_voltage; // Output under-voltage
      logic ext_over_temp; // External sensor over temperature
      logic int_over_temp; // Die over temperature
      logic cable_fault; // Bus line low impedance
      logic cc_over_voltage; // Line over-voltage
      logic vbus_above_safe5v; // Output above vSafe5V
   } sense_s;
   // Power path drive outputs
   typedef struct packed {
      logic [CODE_W-1:0] voltage_reference_level; // Reference code
      logic cc_loop_enable; // Current loop drives feedback
      logic current_amp_decouple; // Current amp cut from feedback
      logic output_bleeder; // Output side bleeder
      logic input_bleeder; // Input side bleeder
      logic load_switch_gate; // Load switch on
      logic line1_pullup_current; // Line 1 pull-up
      logic line2_pullup_current; // Line 2 pull-up
      logic green_mode; // Low power mode
      logic sync_rect_enable; // Synchronous rectifier on
   } drive_s;
endpackage
`default_nettype wire

/* File: test/psb_props.sv */
// Port-level checker of the power-path sequencer
`timescale 1ns/1ns
`default_nettype none
module psb_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire psb_pkg::sense_s sense,
   input wire psb_pkg::drive_s drive
);
   logic win; // Sink seen on either line
   assign win = sense.cc1_in_window | sense.cc2_in_window;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus stalled or errored");
   a_rect_green: assert property (drive.sync_rect_enable |-> !drive.green_mode)
      else $error("rectifier on in green mode");
   a_heavy_no_bleed: assert property (!sense.light_load [*5] |->
      !drive.output_bleeder && !drive.input_bleeder) else $error("bleeder on under heavy load");
   a_fault_drop: assert property (sense.under_voltage [*4] |-> ##[0:2]
      (!drive.load_switch_gate && !drive.line1_pullup_current)) else $error("fault left port up");
   a_loop_decouple: assert property (drive.cc_loop_enable |-> !drive.current_amp_decouple)
      else $error("loop on while decoupled");
   a_pullup_pair: assert property (drive.line1_pullup_current == drive.line2_pullup_current)
      else $error("pull-ups differ");
   a_load_pullup: assert property (drive.load_switch_gate |-> drive.line1_pullup_current)
      else $error("power on with pull-ups off");
   a_restore_idle: assert property ($rose(drive.line1_pullup_current) |->
      !drive.load_switch_gate && drive.green_mode) else $error("pull-ups back while powered");
   a_attach_deb: assert property ($rose(drive.load_switch_gate) |->
      $past(win, 4) && $past(win, 5) && $past(win, 6)) else $error("power before debounce");
endmodule
bind psb_sequencer psb_props u_psb_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .sense(sense), .drive(drive));
`default_nettype wire

/* File: test/sink_model.sv */
// Type-C sink at the port: Rd on one line and the VBUS it sees
`timescale 1ns/1ns
`default_nettype none
module sink_model (
   input wire logic hclk,
   input wire logic attach, // Sink plugged in
   input wire logic flip, // Rd on line 2
   input wire psb_pkg::drive_s drv,
   output logic cc1_win,
   output logic cc2_win,
   output logic vbus_hi
);
   logic [9:0] vb_r = 10'h000; // VBUS level in reference codes
   // Rd holds a line in the window only while the source pulls it up
   assign cc1_win = attach && !flip && drv.line1_pullup_current;
   assign cc2_win = attach && flip && drv.line2_pullup_current;
   assign vbus_hi = vb_r > 10'h0FA;
   // VBUS follows the reference while powered, falls only when bled
   always_ff @(posedge hclk)
   begin
      if (drv.load_switch_gate && vb_r <= drv.voltage_reference_level)
         vb_r <= drv.voltage_reference_level;
      else if (drv.output_bleeder || drv.input_bleeder)
         vb_r <= (vb_r > 10'h020) ? vb_r - 10'h020 : 10'h000;
   end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench of the power-path sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int BA = 20, BB = 30, BC = 40, BD = 50, RS = 60; // Shortened timings
   localparam int GRN = 1, PU = 3, LD = 4, IB = 5, OB = 6; // Drive bit positions
   logic hclk, hresetn, hsel, hwrite, attach, flip, oc, ll, w1, w2, vhi, irq, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [5:0] flt; // Over-volt, under-volt, two temps, cable, line over-volt
   logic [9:0] cur, nxt;
   logic [9:0] tgt [4] = '{10'h28A, 10'h2A3, 10'h289, 10'h270}; // Step and level corners
   psb_pkg::sense_s sense;
   psb_pkg::drive_s drive;
   int n_mismatch = 0, checks_done = 0, cyc = 0, n, k;
   assign sense = {w1, w2, oc, ll, flt, vhi};
   psb_sequencer #(.BLEED_A(BA), .BLEED_B(BB), .BLEED_C(BC), .BLEED_D(BD), .RESTART(RS), .ATTACH_DEB(4),
      .OCP_DEB(4), .OVP_DEL(4), .OVP_BLANK(8)) u_psb_sequencer (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sense(sense),
      .drive(drive), .irq(irq));
   sink_model u_sink_model (.hclk(hclk), .attach(attach), .flip(flip), .drv(drive), .cc1_win(w1),
      .cc2_win(w2), .vbus_hi(vhi));
   // Verdict and end of run
   task automatic finish_test();
   begin
      if (n_mismatch == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   // Compare and report
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
   begin
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   end
   endtask
   // One AHB-Lite word: address phase, then data phase; read data lands in q
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
   begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      q = hrdata;
   end
   endtask
   // Bounded wait for a drive bit; n keeps the cycles spent
   task automatic wt(input int b, input logic v, input int lim);
   begin
      for (n = 0; n < lim && drive[b] !== v; n++)
         @(posedge hclk);
      chk("wait", n < lim, 1);
   end
   endtask
   // Bleed time for a step: small is 25 codes, high is 650 codes
   function automatic int bleed(input logic [9:0] o, input logic [9:0] t);
   begin
      if ((t > o ? t - o : o - t) <= 10'h019)
         return (t >= 10'h28A) ? BA : BB;
      return (t >= 10'h28A) ? BC : BD;
   end
   endfunction
   // Clock
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Hang guard
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   // Main sequence
   initial
   begin
      {hresetn, hsel, hwrite, attach, flip, oc, flt, htrans, haddr, hwdata} = '0;
      ll = 1'b1;
      void'($urandom(41344));
      repeat (2) @(posedge hclk);
      chk("reset drive", drive, {10'h0FA, 9'b010001110});
      hresetn <= 1'b1;
      flip <= 1'($urandom_range(0, 1));
      attach <= 1'b1;
      wt(LD, 1'b1, 40);
      chk("green", drive[GRN], 0);
      bus(0, 8'h0C, 0);
      chk("attach event", q[0], 1);
      chk("irq masked", irq, 0);
      bus(1, 8'h10, 32'h1);
      repeat (2) @(posedge hclk);
      chk("irq on", irq, 1);
      bus(1, 8'h0C, 32'h1);
      repeat (2) @(posedge hclk);
      chk("irq off", irq, 0);
      bus(0, 8'h14, 0);
      chk("unmapped", q, 0);
      // Contract, then voltage steps over every bleed class
      bus(1, 8'h04, 32'h0FA);
      bus(1, 8'h00, 32'h3);
      repeat (4) @(posedge hclk);
      chk("cc loop", drive[8:7], 2'b10);
      cur = 10'h0FA;
      for (k = 0; k < 6; k++)
      begin
         nxt = (k < 4) ? tgt[k] : 10'($urandom_range(260, 1000));
         nxt = (nxt == cur) ? nxt + 10'h001 : nxt;
         bus(1, 8'h04, {22'h0, nxt});
         wt(OB, 1, 20);
         chk("no in bleed", drive[IB], 0);
         wt(OB, 0, 400);
         chk("bleed time", n + 1 >= bleed(cur, nxt) && n <= bleed(cur, nxt) + 1, 1);
         chk("ref code", drive[18:9], nxt);
         chk("load kept", drive[LD], 1);
         cur = nxt;
      end
      // Detach from above 5 V, then hard reset at 5 V
      attach <= 1'b0;
      wt(OB, 1, 20);
      chk("detach high", drive[IB:LD], 2'b01);
      wt(IB, 1, 60);
      chk("detach low", drive[LD], 0);
      wt(OB, 0, 80);
      chk("no contract", drive[8], 0);
      attach <= 1'b1;
      wt(LD, 1, 40);
      bus(1, 8'h00, 32'h4);
      wt(IB, 1, 20);
      chk("hard reset", drive[LD], 0);
      wt(OB, 0, 80);
      // Over-current mode: short pulse ignored, held pulse protects
      wt(LD, 1, 40);
      bus(1, 8'h04, 32'h0FA);
      bus(1, 8'h00, 32'h1);
      repeat (4) @(posedge hclk);
      chk("ocp mode", drive[8:7], 2'b01);
      oc <= 1'b1;
      repeat (3) @(posedge hclk);
      oc <= 1'b0;
      repeat (8) @(posedge hclk);
      chk("short ocp", drive[PU], 1);
      oc <= 1'b1;
      wt(PU, 0, 30);
      chk("prot drive", drive[OB:LD], 3'b110);
      bus(0, 8'h08, 0);
      chk("ocp status", {q[6], q[2:0]}, 4'hC);
      oc <= 1'b0;
      wt(OB, 0, 80);
      chk("restart", drive[IB:PU], 3'b100);
      wt(PU, 1, 100);
      chk("restart time", n + 1 >= RS && n <= RS + 1, 1);
      // Brief over-voltage is filtered by the delay
      flt <= 6'h20;
      repeat (3) @(posedge hclk);
      flt <= 6'h00;
      repeat (8) @(posedge hclk);
      chk("short ovp", drive[PU], 1);
      // Each fault alone, one under heavy load
      for (k = 0; k < 6; k++)
      begin
         ll <= (k != 3);
         flt <= 6'h01 << k;
         wt(PU, 0, 20);
         chk("fault load", drive[LD], 0);
         chk("fault bleed", drive[OB], k != 3);
         repeat ($urandom_range(2, 10)) @(posedge hclk);
         flt <= 6'h00;
         ll <= 1'b1;
         wt(PU, 1, 200);
      end
      finish_test();
   end
endmodule
`default_nettype wire
